// >>> eac_eeprom_access_controller.sv
// Register front end and sequencer for the on-chip EEPROM byte array.
// Assumes a bus master with one-cycle strobes and read data taken in the next cycle.
// Function
// (RULE1) Upper four control bits always read as zero.
// (RULE2) Ready request stays high while enabled, global enable set and no write.
// (RULE3) Write strobe starts a write only while master write arm is set.
// (RULE4) Master write arm clears itself four cycles after software sets it.
// (RULE5) Accepted write stores data at address; write strobe holds until period ends.
// (RULE6) Software arms only with write strobe written zero in the same write.
// (RULE7) Software waits idle, loads address and data, arms, strobes within four cycles.
// (RULE8) Each accepted write strobe stalls the processor two cycles.
// (RULE9) Read strobe loads data from address and clears itself by hardware.
// (RULE10) Each accepted read strobe stalls the processor four cycles.
// (RULE11) Writing address or data during a write aborts that write.
// (RULE12) Software checks write strobe is zero before starting a read.
// (RULE13) Software keeps interrupts off during the last four write steps.
// (RULE14) Twelve-bit byte address; upper four high-byte bits read zero.
// (RULE15) One data register is write source and read destination.
// (RULE16) Write duration is a cycle-count parameter for short simulation.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eac_eeprom_access_controller
	import eac_pkg::*;
#(
	parameter int unsigned WRITE_PERIOD_CYCLES = WRITE_CYCLES
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [1:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        global_irq_enable,
	output logic             ready_irq,
	output logic             cpu_stall
);
	eac_ctrl_t s_reg;
	eac_ctrl_t s_next;
	eac_mem_if mem_if ();
	logic      ctrl_wr;
	logic      arm_set;
	logic      wr_req;
	logic      rd_req;
	logic      abort;
	logic      mem_wr;
	logic      mem_rd;

	localparam logic [WR_CNT_W-1:0] WR_LOAD = WR_CNT_W'(WRITE_PERIOD_CYCLES - 1);

	function automatic logic [7:0] control_byte(input eac_ctrl_t s);
		control_byte = {4'h0, s.irq_en, s.arm, s.st == EAC_ST_WRITE, s.st == EAC_ST_READ}; // [RULE1]
	endfunction

	eac_eeprom_array u_array (
		.sys_clk (sys_clk),
		.rst     (rst),
		.port    (mem_if.mem)
	);

	assign mem_if.addr  = s_reg.addr;
	assign mem_if.wdata = s_reg.data;
	assign mem_if.wr_en = mem_wr;
	assign mem_if.rd_en = mem_rd;

	assign ctrl_wr = reg_wr && (reg_addr == OFF_CONTROL);
	assign arm_set = ctrl_wr && reg_wdata[BIT_MASTER_WRITE_ARM] && !reg_wdata[BIT_WRITE_STROBE]; // [RULE6]
	assign wr_req  = ctrl_wr && reg_wdata[BIT_WRITE_STROBE];
	assign rd_req  = ctrl_wr && reg_wdata[BIT_READ_STROBE];
	assign abort   = (s_reg.st == EAC_ST_WRITE) && reg_wr && (reg_addr != OFF_CONTROL); // [RULE11]

	assign reg_rdata = s_reg.rdata;
	assign ready_irq = s_reg.irq_en && global_irq_enable && (s_reg.st != EAC_ST_WRITE); // [RULE2]
	assign cpu_stall = s_reg.stall_cnt != 3'h0;

	always_comb begin
		s_next = s_reg;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		if (s_reg.arm) begin
			if (s_reg.arm_cnt == 2'h0) begin
				s_next.arm = 1'b0; // [RULE4]
			end else begin
				s_next.arm_cnt = s_reg.arm_cnt - 2'h1;
			end
		end
		if (arm_set) begin
			s_next.arm     = 1'b1; // [RULE4]
			s_next.arm_cnt = ARM_LOAD;
		end
		if (s_reg.stall_cnt != 3'h0) begin
			s_next.stall_cnt = s_reg.stall_cnt - 3'h1;
		end
		if (reg_wr) begin
			case (reg_addr)
				OFF_ADDR_LOW: begin
					s_next.addr[7:0] = reg_wdata;
				end
				OFF_ADDR_HIGH: begin
					s_next.addr[11:8] = reg_wdata[3:0]; // [RULE14]
				end
				OFF_DATA: begin
					s_next.data = reg_wdata; // [RULE15]
				end
				OFF_CONTROL: begin
					s_next.irq_en = reg_wdata[BIT_READY_IRQ_ENABLE];
				end
				default: begin
					s_next.irq_en = s_reg.irq_en;
				end
			endcase
		end
		case (s_reg.st)
			EAC_ST_IDLE: begin
				if (wr_req && s_reg.arm) begin
					s_next.st        = EAC_ST_WRITE; // [RULE3]
					s_next.wr_cnt    = WR_LOAD; // [RULE16]
					s_next.stall_cnt = WR_STALL; // [RULE8]
				end else if (rd_req && !wr_req) begin
					mem_rd           = 1'b1; // [RULE9]
					s_next.st        = EAC_ST_READ;
					s_next.stall_cnt = RD_STALL; // [RULE10]
				end
			end
			EAC_ST_WRITE: begin
				if (abort) begin
					s_next.st = EAC_ST_IDLE; // [RULE11]
				end else if (s_reg.wr_cnt == 20'h00000) begin
					mem_wr    = 1'b1; // [RULE5]
					s_next.st = EAC_ST_IDLE;
				end else begin
					s_next.wr_cnt = s_reg.wr_cnt - 20'h00001;
				end
			end
			EAC_ST_READ: begin
				s_next.data = mem_if.rdata; // [RULE9]
				s_next.st   = EAC_ST_IDLE;
			end
			default: begin
				s_next.st = EAC_ST_IDLE;
			end
		endcase
		if (reg_rd) begin
			case (reg_addr)
				OFF_ADDR_LOW: begin
					s_next.rdata = s_reg.addr[7:0];
				end
				OFF_ADDR_HIGH: begin
					s_next.rdata = {4'h0, s_reg.addr[11:8]}; // [RULE14]
				end
				OFF_DATA: begin
					s_next.rdata = s_reg.data;
				end
				OFF_CONTROL: begin
					s_next.rdata = control_byte(s_reg); // [RULE1]
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_reg <= CTRL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	property p_ctrl_upper_zero;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && reg_addr == OFF_CONTROL) |=> (reg_rdata[7:4] == 4'h0);
	endproperty
	a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("Control upper bits not zero."); // [RULE1]

	property p_ready_irq;
		@(posedge sys_clk) disable iff (rst)
		ready_irq == (s_reg.irq_en && global_irq_enable && s_reg.st != EAC_ST_WRITE);
	endproperty
	a_ready_irq: assert property (p_ready_irq) else $error("Ready request mismatch."); // [RULE2]

	property p_no_write_unarmed;
		@(posedge sys_clk) disable iff (rst)
		(wr_req && !s_reg.arm && s_reg.st == EAC_ST_IDLE) |=> (s_reg.st != EAC_ST_WRITE);
	endproperty
	a_no_write_unarmed: assert property (p_no_write_unarmed) else $error("Write began without arm."); // [RULE3]

	property p_arm_timeout;
		@(posedge sys_clk) disable iff (rst)
		arm_set ##1 (!arm_set) [*4] |-> s_reg.arm ##1 !s_reg.arm;
	endproperty
	a_arm_timeout: assert property (p_arm_timeout) else $error("Arm did not expire after four cycles."); // [RULE4]

	property p_write_accept;
		@(posedge sys_clk) disable iff (rst)
		(wr_req && s_reg.arm && s_reg.st == EAC_ST_IDLE) |=> (s_reg.st == EAC_ST_WRITE && s_reg.wr_cnt == WR_LOAD);
	endproperty
	a_write_accept: assert property (p_write_accept) else $error("Armed write strobe not taken."); // [RULE5]

	property p_write_store;
		@(posedge sys_clk) disable iff (rst)
		(s_reg.st == EAC_ST_WRITE && s_reg.wr_cnt == 20'h00000 && !abort) |-> (mem_if.wr_en ##1 s_reg.st == EAC_ST_IDLE);
	endproperty
	a_write_store: assert property (p_write_store) else $error("Write end did not store byte."); // [RULE5]

	property p_write_stall;
		@(posedge sys_clk) disable iff (rst)
		(wr_req && s_reg.arm && s_reg.st == EAC_ST_IDLE) |=> cpu_stall [*2] ##1 !cpu_stall;
	endproperty
	a_write_stall: assert property (p_write_stall) else $error("Write stall not two cycles."); // [RULE8]

	property p_read_done;
		@(posedge sys_clk) disable iff (rst)
		(mem_if.rd_en) |=> s_reg.st == EAC_ST_READ ##1 (s_reg.st == EAC_ST_IDLE && s_reg.data == $past(mem_if.rdata));
	endproperty
	a_read_done: assert property (p_read_done) else $error("Read did not load data."); // [RULE9]

	property p_read_stall;
		@(posedge sys_clk) disable iff (rst)
		(mem_if.rd_en) |=> cpu_stall [*4] ##1 !cpu_stall;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("Read stall not four cycles."); // [RULE10]

	property p_abort;
		@(posedge sys_clk) disable iff (rst)
		abort |-> (!mem_if.wr_en ##1 s_reg.st == EAC_ST_IDLE);
	endproperty
	a_abort: assert property (p_abort) else $error("Write not aborted."); // [RULE11]

	property p_addr_high_zero;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && reg_addr == OFF_ADDR_HIGH) |=> (reg_rdata[7:4] == 4'h0);
	endproperty
	a_addr_high_zero: assert property (p_addr_high_zero) else $error("Address high upper bits not zero."); // [RULE14]

	property p_ready_busy_low;
		@(posedge sys_clk) disable iff (rst)
		(s_reg.st == EAC_ST_WRITE) |-> !ready_irq;
	endproperty
	a_ready_busy_low: assert property (p_ready_busy_low) else $error("Ready request high during write."); // [RULE2]

	property p_ready_after_write;
		@(posedge sys_clk) disable iff (rst)
		mem_if.wr_en |=> (ready_irq == (s_reg.irq_en && global_irq_enable));
	endproperty
	a_ready_after_write: assert property (p_ready_after_write) else $error("Ready request wrong after write."); // [RULE2]

	property p_arm_hold;
		@(posedge sys_clk) disable iff (rst)
		arm_set |=> s_reg.arm [*4];
	endproperty
	a_arm_hold: assert property (p_arm_hold) else $error("Arm dropped before four cycles."); // [RULE4]

	property p_write_hold;
		@(posedge sys_clk) disable iff (rst)
		(s_reg.st == EAC_ST_WRITE && s_reg.wr_cnt != 20'h00000 && !abort) |=> (s_reg.st == EAC_ST_WRITE);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("Write ended before its period."); // [RULE5]

	property p_busy_readback;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && reg_addr == OFF_CONTROL && s_reg.st == EAC_ST_WRITE) |=> reg_rdata[BIT_WRITE_STROBE];
	endproperty
	a_busy_readback: assert property (p_busy_readback) else $error("Write strobe bit reads zero while busy."); // [RULE5]

	property p_read_clear;
		@(posedge sys_clk) disable iff (rst)
		(s_reg.st == EAC_ST_READ) |=> (s_reg.st == EAC_ST_IDLE);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("Read strobe not cleared."); // [RULE9]

	property p_data_readback;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && reg_addr == OFF_DATA) |=> (reg_rdata == $past(s_reg.data));
	endproperty
	a_data_readback: assert property (p_data_readback) else $error("Data register readback wrong."); // [RULE15]

	property p_addr_low_load;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && reg_addr == OFF_ADDR_LOW) |=> (s_reg.addr[7:0] == $past(reg_wdata));
	endproperty
	a_addr_low_load: assert property (p_addr_low_load) else $error("Address low byte not loaded."); // [RULE14]

	property p_addr_high_load;
		@(posedge sys_clk) disable iff (rst)
		(reg_wr && reg_addr == OFF_ADDR_HIGH) |=> (s_reg.addr[11:8] == $past(reg_wdata[3:0]));
	endproperty
	a_addr_high_load: assert property (p_addr_high_load) else $error("Address high bits not loaded."); // [RULE14]

	property p_unarmed_quiet;
		@(posedge sys_clk) disable iff (rst)
		(wr_req && !s_reg.arm && !rd_req && s_reg.st == EAC_ST_IDLE && !cpu_stall) |=> !cpu_stall;
	endproperty
	a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("Unarmed write strobe had an effect."); // [RULE3]

	property p_stall_idle;
		@(posedge sys_clk) disable iff (rst)
		(!cpu_stall && !wr_req && !rd_req) |=> !cpu_stall;
	endproperty
	a_stall_idle: assert property (p_stall_idle) else $error("Stall without a strobe."); // [RULE8]
endmodule
`default_nettype wire

// >>> eac_eeprom_access_controller_tb.sv
// Self-checking bench of the EEPROM access controller: corner and random writes and reads.
// Assumes eac_pkg, the array, the controller and eac_ref_mem are compiled first.
`timescale 1ns/1ps
`default_nettype none
module eac_eeprom_access_controller_tb;
	import eac_pkg::*;
	localparam int unsigned WP = 20;
	logic        sys_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [1:0]  reg_addr  = 2'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [7:0]  reg_rdata;
	logic        gie       = 1'b1;
	logic        ready_irq;
	logic        cpu_stall;
	logic        m_we      = 1'b0;
	logic [11:0] m_a       = 12'h000;
	logic [7:0]  m_d       = 8'h00;
	logic [7:0]  m_q;
	logic [31:0] seed      = 32'hE40F5F57;
	logic [7:0]  v;
	int          n_mismatch = 0;
	int          checked    = 0;
	int          cyc        = 0;
	int          n;

	eac_eeprom_access_controller #(.WRITE_PERIOD_CYCLES(WP)) dut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.global_irq_enable(gie), .ready_irq(ready_irq), .cpu_stall(cpu_stall));
	eac_ref_mem u_ref (.sys_clk(sys_clk), .we(m_we), .addr(m_a), .wdata(m_d), .rdata(m_q));

	always #4 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic stall_len(output int k);
		k = 0;
		#1;
		while (cpu_stall === 1'b1 && k < 9) begin
			k = k + 1;
			@(posedge sys_clk);
			#1;
		end
	endtask

	task automatic ee_write(input logic [11:0] a, input logic [7:0] d, input int idle,
			input logic [7:0] arm, input logic ok, input logic ab);
		wr(OFF_ADDR_LOW, a[7:0]);
		wr(OFF_ADDR_HIGH, {4'hF, a[11:8]});
		wr(OFF_DATA, d);
		wr(OFF_CONTROL, arm);
		repeat (idle) @(posedge sys_clk);
		wr(OFF_CONTROL, 8'h0A);
		stall_len(n);
		chk(8'(n), ok ? 8'h02 : 8'h00);
		chk({7'h00, ready_irq}, {7'h00, !ok && gie});
		if (ab) begin
			wr(OFF_DATA, ~d);
		end
		n = 0;
		do begin
			rd(OFF_CONTROL, v);
			n = n + 1;
		end while (v[1] === 1'b1 && n < 40);
		chk(v, 8'h08);
		if (ok && !ab) begin
			@(posedge sys_clk);
			m_a  <= a;
			m_d  <= d;
			m_we <= 1'b1;
			@(posedge sys_clk);
			m_we <= 1'b0;
		end
	endtask

	task automatic ee_read(input logic [11:0] a);
		wr(OFF_ADDR_LOW, a[7:0]);
		wr(OFF_ADDR_HIGH, {4'hA, a[11:8]});
		m_a <= a;
		wr(OFF_CONTROL, 8'h09);
		stall_len(n);
		chk(8'(n), 8'h04);
		rd(OFF_DATA, v);
		chk(v, m_q);
		rd(OFF_CONTROL, v);
		chk(v, 8'h08);
		rd(OFF_ADDR_HIGH, v);
		chk(v, {4'h0, a[11:8]});
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rd(OFF_CONTROL, v);
		chk(v, 8'h00);
		chk({7'h00, ready_irq}, 8'h00);
		ee_write(12'hFFF, 8'h5A, 2, 8'h0C, 1'b1, 1'b0);
		ee_read(12'hFFF);
		ee_write(12'hFFF, 8'hC3, 3, 8'h0C, 1'b0, 1'b0);
		ee_write(12'hFFF, 8'h3C, 0, 8'h0E, 1'b0, 1'b0);
		ee_write(12'hFFF, 8'h99, 0, 8'h0C, 1'b1, 1'b1);
		ee_read(12'hFFF);
		ee_write(12'h000, 8'h00, 1, 8'h0C, 1'b1, 1'b0);
		ee_read(12'h000);
		repeat (6) begin
			seed = xs(seed);
			@(posedge sys_clk);
			gie <= seed[20];
			ee_write(seed[11:0], seed[19:12], int'(seed[21]), 8'h0C, 1'b1, 1'b0);
			ee_read(seed[11:0]);
		end
		@(posedge sys_clk);
		gie <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk({7'h00, ready_irq}, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire

// >>> eac_eeprom_array.sv
// Byte array of 4096 locations with registered read data.
// Assumes the controller issues at most one read or one write per cycle.
`timescale 1ns/1ps
`default_nettype none
module eac_eeprom_array
	import eac_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  rst,
	eac_mem_if.mem     port
);
	logic [DATA_W-1:0] cells [0:DEPTH-1];
	eac_mem_state_t    s_reg;
	eac_mem_state_t    s_next;

	assign port.rdata = s_reg.rdata;

	always_comb begin
		s_next = s_reg;
		if (port.rd_en) begin
			s_next.rdata = cells[port.addr];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_reg <= MEM_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// The array itself keeps its contents through reset.
	always_ff @(posedge sys_clk) begin
		if (port.wr_en) begin
			cells[port.addr] <= port.wdata;
		end
	end
endmodule
`default_nettype wire

// >>> eac_mem_if.sv
// Carrier between the access controller and its byte array.
// Assumes both ends share one clock; read data come one cycle after rd_en.
`timescale 1ns/1ps
`default_nettype none
interface eac_mem_if;
	import eac_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr_en;
	logic              rd_en;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output addr, output wdata, output wr_en, output rd_en, input rdata);
	modport mem  (input addr, input wdata, input wr_en, input rd_en, output rdata);
endinterface
`default_nettype wire

// >>> eac_pkg.sv
// Constants, types and the register map of the EEPROM access controller.
// Assumes a single 125 MHz clock shared by every user of this package.
package eac_pkg;

	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned WRITE_TIME_NS = 4000000;
	localparam int unsigned WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned WR_CNT_W      = 20;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned DEPTH  = 4096;

	localparam logic [1:0] OFF_ADDR_LOW  = 2'h0;
	localparam logic [1:0] OFF_ADDR_HIGH = 2'h1;
	localparam logic [1:0] OFF_DATA      = 2'h2;
	localparam logic [1:0] OFF_CONTROL   = 2'h3;

	localparam int unsigned BIT_READY_IRQ_ENABLE  = 3;
	localparam int unsigned BIT_MASTER_WRITE_ARM  = 2;
	localparam int unsigned BIT_WRITE_STROBE      = 1;
	localparam int unsigned BIT_READ_STROBE       = 0;

	localparam logic [1:0] ARM_LOAD     = 2'h3;
	localparam logic [2:0] WR_STALL     = 3'h2;
	localparam logic [2:0] RD_STALL     = 3'h4;

	typedef enum logic [2:0] {
		EAC_ST_IDLE  = 3'b001,
		EAC_ST_WRITE = 3'b010,
		EAC_ST_READ  = 3'b100
	} eac_state_t;

	typedef struct packed {
		eac_state_t          st;
		logic                irq_en;
		logic                arm;
		logic [1:0]          arm_cnt;
		logic [WR_CNT_W-1:0] wr_cnt;
		logic [2:0]          stall_cnt;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
		logic [DATA_W-1:0]   rdata;
	} eac_ctrl_t;

	localparam eac_ctrl_t CTRL_RESET = '{
		st:        EAC_ST_IDLE,
		irq_en:    1'b0,
		arm:       1'b0,
		arm_cnt:   2'h0,
		wr_cnt:    20'h00000,
		stall_cnt: 3'h0,
		addr:      12'h000,
		data:      8'h00,
		rdata:     8'h00
	};

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
	} eac_mem_state_t;

	localparam eac_mem_state_t MEM_RESET = '{rdata: 8'h00};

endpackage

// >>> eac_ref_mem.sv
// Reference copy of the byte array contents, used to predict read results.
// Assumes the bench commits a byte only for writes that complete without abort.
`timescale 1ns/1ps
`default_nettype none
module eac_ref_mem
	import eac_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	output logic      [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [DEPTH];
	// A committed write stores the byte at its full twelve-bit address.
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
	// The same location answers reads, so one byte serves both directions.
	assign rdata = mem[addr];
endmodule
`default_nettype wire
